// File: core/i2c_cfg_pkg.sv
// Purpose: Shared constants and types for the I2C configuration register bank.
// Assumes: 8-bit registers, one paged group and one global page selector.
// Notes: Defaults model the non-volatile image loaded at every reset.
package i2c_cfg_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus addressing and paging.
  localparam logic [6:0] TARGET_ADDR_BASE = 7'h20;
  localparam int STRAP_BITS = 2;
  localparam logic [7:0] PAGE_SEL_ADDR = 8'hef;
  localparam logic [7:0] PAGE_SEL_DEFAULT = 8'h80;
  localparam logic [7:0] CFG_PAGE = 8'h82;
  localparam int REG_COUNT = 40;
  localparam logic [7:0] LAST_PAGED_ADDR = 8'h27;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and link rates.
  localparam int MCLK_HZ = 20000000;
  localparam int STD_RATE_KBPS = 100;
  localparam int FAST_RATE_KBPS = 400;
  localparam int FAST_BIT_CYC = MCLK_HZ / (FAST_RATE_KBPS * 1000);
  localparam int STD_BIT_CYC = MCLK_HZ / (STD_RATE_KBPS * 1000);
  localparam int SYNC_STAGES = 3;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets in the configuration page.
  localparam logic [7:0] RAIL_A_TRANSITION_COMP_CFG = 8'h00;
  localparam logic [7:0] RAIL_B_TRANSITION_COMP_CFG = 8'h01;
  localparam logic [7:0] RAIL_C_TRANSITION_COMP_CFG = 8'h02;
  localparam logic [7:0] RAIL_A_ONTIME_RIPPLE_CFG = 8'h03;
  localparam logic [7:0] RAIL_B_ONTIME_RIPPLE_CFG = 8'h04;
  localparam logic [7:0] RAIL_C_ONTIME_RIPPLE_CFG = 8'h05;
  localparam logic [7:0] FAST_VMODE_UNDERVOLT_MISC_CFG = 8'h06;
  localparam logic [7:0] TEMP_SENSE_SELECT_CFG = 8'h07;
  localparam logic [7:0] FAST_VMODE_NONOVERLAP_CFG = 8'h08;
  localparam logic [7:0] SINGLE_PHASE_MGMT_RAMP_CFG = 8'h09;
  localparam logic [7:0] RIPPLE_COMP_MISC_AB_CFG = 8'h0a;
  localparam logic [7:0] RAIL_A_CURRENT_LIMIT_CFG = 8'h10;
  localparam logic [7:0] CURRENT_LIMIT_BOOT_SLEW_CFG = 8'h11;
  localparam logic [7:0] RAIL_B_CURRENT_LIMIT_CFG = 8'h12;
  localparam logic [7:0] RAIL_C_CURRENT_LIMIT_CFG = 8'h13;
  localparam logic [7:0] ZERO_LOADLINE_CFG = 8'h14;
  localparam logic [7:0] ONTIME_GAIN_AB_CFG = 8'h15;
  localparam logic [7:0] ONTIME_C_CURRENT_GAIN_AB_CFG = 8'h16;
  localparam logic [7:0] CURRENT_GAIN_BC_PHASE_MGMT_EN = 8'h17;
  localparam logic [7:0] DOUBLER_PHASE_SENSE_SELECT = 8'h18;
  localparam logic [7:0] RAIL_D_CURRENT_LIMIT_CFG = 8'h19;
  localparam logic [7:0] RAIL_A_OVERSHOOT_GUARD_CFG = 8'h1a;
  localparam logic [7:0] RAIL_A_QUICK_RESPONSE_THRESH = 8'h1b;
  localparam logic [7:0] RAIL_B_QUICK_RESPONSE_THRESH = 8'h1c;
  localparam logic [7:0] RAMP_RESPONSE_THRESH_AB = 8'h1d;
  localparam logic [7:0] RAMP_THRESH_C_ZERO_CROSS_AB = 8'h1e;
  localparam logic [7:0] ZERO_CROSS_C_LIMIT_D_CFG = 8'h1f;
  localparam logic [7:0] FILTER_INITIAL_AB_CFG = 8'h20;
  localparam logic [7:0] POWER_STAGE_DOUBLER_FILTER_C_CFG = 8'h21;
  localparam logic [7:0] TRANSITION_LIFT_AB_CFG = 8'h22;
  localparam logic [7:0] TRANSITION_LIFT_C_CFG = 8'h23;
  localparam logic [7:0] SYS_POWER_TRISTATE_ZERO_CFG = 8'h24;
  localparam logic [7:0] RAIL_A_LOADLINE_FILTER_OFFSET = 8'h25;
  localparam logic [7:0] RAIL_B_LOADLINE_FILTER_OFFSET = 8'h26;
  localparam logic [7:0] RAIL_C_LOADLINE_FILTER_OFFSET = 8'h27;

  ////////////////////////////////////////////////////////////////////////////
  // Register image types and the stored defaults.
  typedef logic [7:0] byte_t;
  typedef logic [REG_COUNT-1:0][7:0] reg_array_t;
  typedef struct packed {
    byte_t page;
    reg_array_t regs;
  } cfg_view_t;

  // Offsets 0x0b to 0x0f hold no register.
  localparam logic [REG_COUNT-1:0] REG_MAPPED = 40'hffffff07ff;
  // Highest offset first.
  localparam reg_array_t REG_DEFAULTS = {
    8'h20, 8'h20, 8'he0, 8'h05, 8'h32, 8'h54, 8'h3e, 8'h11,
    8'h02, 8'he0, 8'hb6, 8'h55, 8'h21, 8'hc0, 8'h20, 8'h00,
    8'ha7, 8'h3f, 8'h34, 8'h00, 8'h28, 8'h51, 8'h22, 8'hb0,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h07, 8'h00,
    8'h10, 8'h21, 8'h80, 8'h00, 8'h80, 8'hc2, 8'hc4, 8'h4c
  };

endpackage

// File: core/pin_sync.sv
// Purpose: Three-stage synchroniser with an agreement filter for pin inputs.
// Assumes: Inputs are asynchronous to mclk.
// Notes: The output level moves only when the second and third stages agree.
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] RESET_LEVEL = '1
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic srst,
  // Raw pins and filtered levels.
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] level
);

  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
    logic [WIDTH-1:0] third;
    logic [WIDTH-1:0] level;
  } sync_state_t;

  sync_state_t cur;
  sync_state_t next_cur;

  always_comb begin
    next_cur = cur;
    next_cur.first = pinIn;
    next_cur.second = cur.first;
    next_cur.third = cur.second;
    for (int i = 0; i < WIDTH; i++) begin
      if (cur.second[i] == cur.third[i]) begin
        next_cur.level[i] = cur.third[i];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      cur <= {RESET_LEVEL, RESET_LEVEL, RESET_LEVEL, RESET_LEVEL};
    end else begin
      cur <= next_cur;
    end
  end

  assign level = cur.level;

endmodule

// File: core/i2c_config_register_bank.sv
// Purpose: I2C target port with the paged configuration register bank.
// Assumes: SCL and SDA are open-drain pins sampled on mclk; strap pins are static.
// Notes: Registers reload their stored defaults on every reset.
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
module i2c_config_register_bank (
  // Clock and reset.
  input wire logic mclk,
  input wire logic srst,
  // I2C pins.
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOeN,
  // Address straps.
  input wire logic [i2c_cfg_pkg::STRAP_BITS-1:0] addrSel,
  // Configuration image towards the regulator.
  output i2c_cfg_pkg::cfg_view_t cfgView
);

  //////////////////////////////////////////////////////////////////////////////
  // Types and state.
  typedef enum logic [3:0] {
    IDLE = 4'h0,
    DEV_ADDR = 4'h1,
    DEV_ACK = 4'h3,
    REG_ADDR = 4'h2,
    REG_ACK = 4'h6,
    WR_BYTE = 4'h7,
    WR_ACK = 4'h5,
    RD_BYTE = 4'h4,
    RD_ACK = 4'hc
  } xfer_state_t;

  typedef struct packed {
    xfer_state_t st;
    logic [3:0] bitCnt;
    i2c_cfg_pkg::byte_t shift;
    logic readDir;
    logic hostAck;
    i2c_cfg_pkg::byte_t ptr;
    logic sdaLow;
    logic sclPrev;
    logic sdaPrev;
    logic [i2c_cfg_pkg::STRAP_BITS-1:0] strap;
    i2c_cfg_pkg::byte_t page;
    i2c_cfg_pkg::reg_array_t regs;
  } state_t;

  state_t cur;
  state_t next_cur;

  logic scl;
  logic sda;
  logic [i2c_cfg_pkg::STRAP_BITS-1:0] strapPin;
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;
  logic addrHit;
  logic pagedHit;
  logic [6:0] ownAddr;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation.
  pin_sync #(
    .WIDTH(i2c_cfg_pkg::STRAP_BITS + 2),
    .RESET_LEVEL({{i2c_cfg_pkg::STRAP_BITS{1'b0}}, 2'b11})
  ) u_pin_sync (
    .mclk(mclk),
    .srst(srst),
    .pinIn({addrSel, sdaIn, sclIn}),
    .level({strapPin, sda, scl})
  );

  //////////////////////////////////////////////////////////////////////////////
  // Bus events.
  assign sclRise = scl && !cur.sclPrev;
  assign sclFall = !scl && cur.sclPrev;
  assign startSeen = scl && cur.sclPrev && cur.sdaPrev && !sda;
  assign stopSeen = scl && cur.sclPrev && !cur.sdaPrev && sda;
  assign ownAddr = {i2c_cfg_pkg::TARGET_ADDR_BASE[6:i2c_cfg_pkg::STRAP_BITS], cur.strap};
  assign addrHit = (cur.shift[7:1] == ownAddr);
  assign pagedHit = (cur.page == i2c_cfg_pkg::CFG_PAGE) && (cur.ptr <= i2c_cfg_pkg::LAST_PAGED_ADDR)
                    && i2c_cfg_pkg::REG_MAPPED[cur.ptr[5:0]];

  // Unmapped offsets and foreign pages read as zero.
  function automatic i2c_cfg_pkg::byte_t readByte(input state_t s, input logic hit);
    i2c_cfg_pkg::byte_t val;
    val = 8'h00;
    if (s.ptr == i2c_cfg_pkg::PAGE_SEL_ADDR) begin
      val = s.page;
    end else if (hit) begin
      val = s.regs[s.ptr[5:0]];
    end
    return val;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic.
  always_comb begin
    next_cur = cur;
    next_cur.sclPrev = scl;
    next_cur.sdaPrev = sda;
    if (cur.st == IDLE) begin
      next_cur.strap = strapPin;
    end
    if (startSeen) begin
      next_cur.st = DEV_ADDR;
      next_cur.bitCnt = 4'h0;
      next_cur.sdaLow = 1'b0;
    end else if (stopSeen) begin
      next_cur.st = IDLE;
      next_cur.sdaLow = 1'b0;
    end else begin
      unique case (cur.st)
        IDLE: begin
          next_cur.sdaLow = 1'b0;
        end
        DEV_ADDR, REG_ADDR, WR_BYTE: begin
          if (sclRise) begin
            next_cur.shift = {cur.shift[6:0], sda};
            next_cur.bitCnt = cur.bitCnt + 4'h1;
          end else if (sclFall && cur.bitCnt == i2c_cfg_pkg::BITS_PER_BYTE) begin
            next_cur.bitCnt = 4'h0;
            next_cur.sdaLow = 1'b1;
            if (cur.st == DEV_ADDR) begin
              if (addrHit) begin
                next_cur.st = DEV_ACK;
                next_cur.readDir = cur.shift[0];
              end else begin
                next_cur.st = IDLE;
                next_cur.sdaLow = 1'b0;
              end
            end else if (cur.st == REG_ADDR) begin
              next_cur.ptr = cur.shift;
              next_cur.st = REG_ACK;
            end else begin
              if (cur.ptr == i2c_cfg_pkg::PAGE_SEL_ADDR) begin
                next_cur.page = cur.shift;
              end else if (pagedHit) begin
                next_cur.regs[cur.ptr[5:0]] = cur.shift;
              end
              next_cur.ptr = cur.ptr + 8'h01;
              next_cur.st = WR_ACK;
            end
          end
        end
        DEV_ACK: begin
          if (sclFall) begin
            next_cur.bitCnt = 4'h0;
            if (cur.readDir) begin
              next_cur.shift = readByte(cur, pagedHit);
              next_cur.sdaLow = !next_cur.shift[7];
              next_cur.st = RD_BYTE;
            end else begin
              next_cur.sdaLow = 1'b0;
              next_cur.st = REG_ADDR;
            end
          end
        end
        REG_ACK, WR_ACK: begin
          if (sclFall) begin
            next_cur.sdaLow = 1'b0;
            next_cur.bitCnt = 4'h0;
            next_cur.st = WR_BYTE;
          end
        end
        RD_BYTE: begin
          if (sclRise) begin
            next_cur.bitCnt = cur.bitCnt + 4'h1;
          end else if (sclFall) begin
            if (cur.bitCnt == i2c_cfg_pkg::BITS_PER_BYTE) begin
              next_cur.sdaLow = 1'b0;
              next_cur.ptr = cur.ptr + 8'h01;
              next_cur.st = RD_ACK;
            end else begin
              next_cur.shift = {cur.shift[6:0], 1'b0};
              next_cur.sdaLow = !cur.shift[6];
            end
          end
        end
        RD_ACK: begin
          if (sclRise) begin
            next_cur.hostAck = !sda;
          end else if (sclFall) begin
            next_cur.bitCnt = 4'h0;
            if (cur.hostAck) begin
              next_cur.shift = readByte(cur, pagedHit);
              next_cur.sdaLow = !next_cur.shift[7];
              next_cur.st = RD_BYTE;
            end else begin
              next_cur.sdaLow = 1'b0;
              next_cur.st = IDLE;
            end
          end
        end
        default: begin
          next_cur.st = IDLE;
          next_cur.sdaLow = 1'b0;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register.
  always_ff @(posedge mclk) begin
    if (srst) begin
      cur <= '0;
      cur.st <= IDLE;
      cur.sclPrev <= 1'b1;
      cur.sdaPrev <= 1'b1;
      cur.page <= i2c_cfg_pkg::PAGE_SEL_DEFAULT;
      cur.regs <= i2c_cfg_pkg::REG_DEFAULTS;
    end else begin
      cur <= next_cur;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs.
  // SCL is never driven, so the host sets the pace of every bit.
  assign sdaOut = 1'b0;
  assign sdaOeN = !cur.sdaLow;
  assign cfgView.page = cur.page;
  assign cfgView.regs = cur.regs;

  //////////////////////////////////////////////////////////////////////////////
  // Checks.
  localparam int FAST_BIT_CYC = i2c_cfg_pkg::FAST_BIT_CYC;
  logic [7:0] lowAge;

  // Counts cycles since SCL was last seen falling.
  always_ff @(posedge mclk) begin
    if (srst || sclFall) begin
      lowAge <= 8'h00;
    end else if (lowAge != 8'hff) begin
      lowAge <= lowAge + 8'h01;
    end
  end

  chk_addr_miss: assert property (@(posedge mclk) disable iff (srst)
    (cur.st == DEV_ADDR && sclFall && !startSeen && !stopSeen && cur.bitCnt == 4'h8 && !addrHit)
    |=> (cur.st == IDLE && !cur.sdaLow))
    else $error("foreign address was acknowledged");

  chk_addr_ack: assert property (@(posedge mclk) disable iff (srst)
    (cur.st == DEV_ADDR && sclFall && !startSeen && !stopSeen && cur.bitCnt == 4'h8 && addrHit)
    |=> (cur.st == DEV_ACK && cur.sdaLow && !sdaOeN))
    else $error("own address was not acknowledged");

  chk_bit_follows: assert property (@(posedge mclk) disable iff (srst)
    (sclRise && !startSeen && !stopSeen && (cur.st == DEV_ADDR || cur.st == WR_BYTE))
    |=> (cur.bitCnt == $past(cur.bitCnt) + 4'h1))
    else $error("a host clock edge was not counted");

  chk_sda_low_phase: assert property (@(posedge mclk) disable iff (srst)
    ($changed(cur.sdaLow) && !$past(startSeen) && !$past(stopSeen))
    |-> (!scl && lowAge == 8'h00 && FAST_BIT_CYC > i2c_cfg_pkg::SYNC_STAGES + 1))
    else $error("SDA moved outside the start of the SCL low phase");

  chk_next_byte: assert property (@(posedge mclk) disable iff (srst)
    (cur.st == WR_ACK && sclFall && !startSeen && !stopSeen)
    |=> (cur.st == WR_BYTE && cur.bitCnt == 4'h0 && !cur.sdaLow))
    else $error("no further data byte accepted after acknowledge");

  chk_ptr_step: assert property (@(posedge mclk) disable iff (srst)
    (cur.st == WR_BYTE && sclFall && !startSeen && !stopSeen && cur.bitCnt == 4'h8)
    |=> (cur.ptr == $past(cur.ptr) + 8'h01) ##1 (cur.st == WR_ACK || cur.st == IDLE || cur.st == DEV_ADDR))
    else $error("register pointer did not advance by one");

  chk_paged_write: assert property (@(posedge mclk) disable iff (srst)
    (cur.st == WR_BYTE && sclFall && !startSeen && !stopSeen && cur.bitCnt == 4'h8 && pagedHit)
    |=> (cur.regs[$past(cur.ptr[5:0])] == $past(cur.shift)))
    else $error("paged register write was lost");

  chk_page_guard: assert property (@(posedge mclk) disable iff (srst)
    (cur.page != i2c_cfg_pkg::CFG_PAGE) |=> $stable(cur.regs))
    else $error("paged register changed while another page was selected");

  chk_page_write: assert property (@(posedge mclk) disable iff (srst)
    (cur.st == WR_BYTE && sclFall && !startSeen && !stopSeen && cur.bitCnt == 4'h8
     && cur.ptr == i2c_cfg_pkg::PAGE_SEL_ADDR)
    |=> (cur.page == $past(cur.shift) && $stable(cur.regs)))
    else $error("page selector write was lost");

  chk_foreign_drop: assert property (@(posedge mclk) disable iff (srst)
    (cur.st == WR_BYTE && sclFall && !startSeen && !stopSeen && cur.bitCnt == 4'h8 && !pagedHit)
    |=> $stable(cur.regs))
    else $error("a byte for an unreachable offset reached the bank");

  chk_read_step: assert property (@(posedge mclk) disable iff (srst)
    (cur.st == RD_BYTE && sclFall && !startSeen && !stopSeen && cur.bitCnt == 4'h8)
    |=> (cur.st == RD_ACK && !cur.sdaLow && cur.ptr == $past(cur.ptr) + 8'h01))
    else $error("read pointer did not advance after a byte");

  chk_read_more: assert property (@(posedge mclk) disable iff (srst)
    (cur.st == RD_ACK && sclFall && !startSeen && !stopSeen && cur.hostAck)
    |=> (cur.st == RD_BYTE && cur.bitCnt == 4'h0))
    else $error("no further read byte after host acknowledge");

  chk_read_end: assert property (@(posedge mclk) disable iff (srst)
    (cur.st == RD_ACK && sclFall && !startSeen && !stopSeen && !cur.hostAck)
    |=> (cur.st == IDLE && !cur.sdaLow))
    else $error("SDA still held after the host ended the read");

  // While a byte is sent, the pin enable must mirror the bit now at the top of the shifter.
  chk_read_bit: assert property (@(posedge mclk) disable iff (srst)
    (cur.st == RD_BYTE) |-> (sdaOeN == cur.shift[7]))
    else $error("read data bit on SDA differs from the register bit");

  chk_stop_idle: assert property (@(posedge mclk) disable iff (srst)
    stopSeen |=> (cur.st == IDLE && !cur.sdaLow))
    else $error("port did not return to idle after a stop");

  chk_strap_hold: assert property (@(posedge mclk) disable iff (srst)
    (cur.st != IDLE) |=> $stable(cur.strap))
    else $error("address straps changed during a transfer");

  chk_page_default: assert property (@(posedge mclk) disable iff (srst)
    $past(srst) |-> (cur.page == i2c_cfg_pkg::PAGE_SEL_DEFAULT && cfgView.page == cur.page))
    else $error("page selector missed its default after reset");

  for (genvar i = 0; i < i2c_cfg_pkg::REG_COUNT; i++) begin : g_reg_chk
    chk_reset_image: assert property (@(posedge mclk) disable iff (srst)
      $past(srst) |-> (cur.regs[i] == i2c_cfg_pkg::REG_DEFAULTS[i]))
      else $error("register missed its stored default after reset");
    if (!i2c_cfg_pkg::REG_MAPPED[i]) begin : g_hole
      chk_hole_fixed: assert property (@(posedge mclk) disable iff (srst)
        cur.regs[i] == 8'h00)
        else $error("unmapped offset took a value");
    end
  end

endmodule

// File: dv/i2c_host_model.sv
// Purpose: Bit-level I2C host that drives SCL and releases or pulls SDA.
// Assumes: Both lines have pull-ups; the bench resolves SDA from all drivers.
// Notes: The quarter-bit length q is in mclk cycles and sets the bus rate.
`timescale 1ns/1ps
module i2c_host_model (
  // Clock.
  input wire logic mclk,
  // Bus lines.
  input wire logic sdaLine,
  output logic scl,
  output logic sdaRel
);
  // Thirteen cycles give 385 kbit/s and fifty give 100 kbit/s.
  int q = 13;

  initial begin
    scl = 1'b1;
    sdaRel = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // The host keeps its own pace and never waits on SCL.
  task automatic pause(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic start_cond();
    sdaRel = 1'b1;
    pause(q);
    scl = 1'b1;
    pause(q);
    sdaRel = 1'b0;
    pause(q);
    scl = 1'b0;
    pause(q);
  endtask

  task automatic stop_cond();
    sdaRel = 1'b0;
    pause(q);
    scl = 1'b1;
    pause(q);
    sdaRel = 1'b1;
    pause(q);
  endtask

  task automatic xfer_bit(input logic b, output logic got);
    sdaRel = b;
    pause(q);
    scl = 1'b1;
    pause(q);
    got = sdaLine;
    pause(q);
    scl = 1'b0;
    pause(q);
  endtask

  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(d[i], g);
    end
    xfer_bit(1'b1, g);
    ack = ~g;
  endtask

  task automatic recv_byte(input logic more, output logic [7:0] d);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(1'b1, g);
      d[i] = g;
    end
    xfer_bit(~more, g);
  endtask
endmodule

// File: dv/tb_i2c_config_register_bank.sv
// Purpose: Self-checking bench for the I2C configuration register bank.
// Assumes: 20 MHz mclk; the host model paces the bus at fast or standard rate.
// Notes: SDA is the wired-AND of host and device with a pull-up.
`timescale 1ns/1ps
module tb_i2c_config_register_bank;
  logic mclk;
  logic srst;
  logic scl;
  logic sdaRel;
  logic sdaIn;
  logic sdaOut;
  logic sdaOeN;
  logic [1:0] addrSel;
  logic [6:0] dev;
  i2c_cfg_pkg::cfg_view_t cfgView;
  i2c_cfg_pkg::byte_t expQ[$];
  int nFail = 0;
  int checked = 0;
  int cycles = 0;

  assign sdaIn = sdaRel & (sdaOeN | sdaOut);
  assign dev = 7'h20 | {5'h00, addrSel};

  i2c_host_model host (.mclk(mclk), .sdaLine(sdaIn), .scl(scl), .sdaRel(sdaRel));

  i2c_config_register_bank uut (
    .mclk(mclk), .srst(srst), .sclIn(scl), .sdaIn(sdaIn), .sdaOut(sdaOut),
    .sdaOeN(sdaOeN), .addrSel(addrSel), .cfgView(cfgView)
  );

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d mismatches %0d", checked, nFail);
    if (nFail == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 80000) begin
      nFail++;
      $display("unexpected at %0t: run did not finish in time", $time);
      results();
    end
  end

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      nFail++;
      $display("unexpected at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_ack(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      nFail++;
      $display("unexpected at %0t: acknowledge %b expected %b", $time, got, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Writes carry whole bytes whose reserved bits the caller keeps.
  task automatic wr_regs(input logic [6:0] a, input logic [7:0] ra, input i2c_cfg_pkg::byte_t d[$],
                         input logic expAck);
    logic k;
    host.start_cond();
    host.send_byte({a, 1'b0}, k);
    chk_ack(k, expAck);
    if (expAck) begin
      host.send_byte(ra, k);
      chk_ack(k, 1'b1);
      foreach (d[i]) begin
        host.send_byte(d[i], k);
        chk_ack(k, 1'b1);
      end
    end
    host.stop_cond();
  endtask

  task automatic rd_chk(input logic [7:0] ra, input i2c_cfg_pkg::byte_t e[$]);
    logic k;
    logic [7:0] b;
    host.start_cond();
    host.send_byte({dev, 1'b0}, k);
    chk_ack(k, 1'b1);
    host.send_byte(ra, k);
    chk_ack(k, 1'b1);
    host.start_cond();
    host.send_byte({dev, 1'b1}, k);
    chk_ack(k, 1'b1);
    foreach (e[i]) begin
      host.recv_byte(i < e.size() - 1, b);
      chk_byte(b, e[i]);
    end
    host.stop_cond();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    srst = 1'b1;
    addrSel = 2'h1;
    repeat (20) @(posedge mclk);
    #1 srst = 1'b0;
    host.pause(10);
    chk_byte(cfgView.page, 8'h80);
    for (int i = 0; i < 40; i++) begin
      chk_byte(cfgView.regs[i], i2c_cfg_pkg::REG_DEFAULTS[i]);
    end
    rd_chk(8'hef, {8'h80});
    $display("test reset image done");

    // Bank offsets are out of reach until the page selects the bank.
    wr_regs(dev, 8'h10, {8'h5a}, 1'b1);
    chk_byte(cfgView.regs[16], 8'hb0);
    rd_chk(8'h10, {8'h00});
    wr_regs(dev, 8'hef, {8'h82}, 1'b1);
    chk_byte(cfgView.page, 8'h82);
    $display("test page gate done");

    expQ = {};
    for (int i = 0; i < 40; i++) begin
      expQ.push_back(i2c_cfg_pkg::REG_DEFAULTS[i]);
    end
    rd_chk(8'h00, expQ);
    $display("test burst read done");

    // Bursts run past the last register and into the hole after 0x0a.
    wr_regs(dev, 8'h26, {8'h3c, 8'hc3, 8'h99}, 1'b1);
    chk_byte(cfgView.regs[38], 8'h3c);
    chk_byte(cfgView.regs[39], 8'hc3);
    rd_chk(8'h26, {8'h3c, 8'hc3, 8'h00});
    wr_regs(dev, 8'h0a, {8'h81, 8'h7e}, 1'b1);
    chk_byte(cfgView.regs[10], 8'h81);
    chk_byte(cfgView.regs[11], 8'h00);
    rd_chk(8'h0a, {8'h81, 8'h00});
    $display("test burst write done");

    for (int s = 0; s < 4; s++) begin
      addrSel = s[1:0];
      host.pause(10);
      wr_regs(7'h20 | {5'h00, addrSel ^ 2'h1}, 8'h1b, {8'h00}, 1'b0);
      wr_regs(dev, 8'h1b, {8'h30 + s[7:0]}, 1'b1);
      chk_byte(cfgView.regs[27], 8'h30 + s[7:0]);
    end
    $display("test address straps done");

    host.q = 50;
    wr_regs(dev, 8'h00, {8'h4d, 8'hc5}, 1'b1);
    rd_chk(8'h00, {8'h4d, 8'hc5});
    host.q = 13;
    $display("test standard rate done");

    srst = 1'b1;
    host.pause(4);
    srst = 1'b0;
    host.pause(10);
    chk_byte(cfgView.page, 8'h80);
    chk_byte(cfgView.regs[0], 8'h4c);
    chk_byte(cfgView.regs[38], 8'h20);
    rd_chk(8'hef, {8'h80});
    $display("test second reset done");
    results();
  end
endmodule
